// File: core/kwu_key_wakeup_unit.sv
// Key-on wakeup unit: stop entry, refusal and release from pin and keys.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module kwsr_key_wakeup_unit
    import kwsr_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] key_wake_in,
    input wire logic stop_pin,
    input wire logic stop_cmd,
    output logic release_req,
    output logic stop_mode,
    output logic warmup_start
);

    logic [3:0] key_en_r;
    logic level_mode_r;
    logic pin_prev_r;
    logic warmup_r;
    logic [7:0] rdata_r;
    kwsr_state_t state_r;
    kwsr_state_t state_nxt;
    logic [3:0] key_low;
    logic key_release;
    logic wake;

    // =========================================================
    // Status decode
    // The raw key levels sit beside the stop flag so that software can
    // confirm every enabled key is high before it asks for stop.
    function automatic logic [7:0] status_word(input logic [3:0] keys,
        input logic stopped);
        logic [7:0] word;
        word = 8'h00;
        word[KWSR_STAT_KEY_LSB +: KWSR_KEYS] = keys;
        word[KWSR_STAT_STOP_BIT] = stopped;
        return word;
    endfunction

    // =========================================================
    // Register port
    // Enable bits take effect at once, so a low key can refuse the next stop.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            key_en_r <= KWSR_EN_RESET;
        end else if (reg_wr && reg_addr == KWSR_ENABLE_ADDR) begin
            key_en_r <= reg_wdata[KWSR_EN_MSB:KWSR_EN_LSB];
        end
    end

    // Release mode comes up as level mode, the safer of the two.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level_mode_r <= KWSR_REL_MODE_RESET;
        end else if (reg_wr && reg_addr == KWSR_CTRL_ADDR) begin
            level_mode_r <= reg_wdata[KWSR_REL_MODE_BIT];
        end
    end

    // The enable register is write-only, so it reads back as zero; read
    // data stand for one cycle and then fall back to zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= KWSR_RDATA_RESET;
        end else if (reg_rd) begin
            unique case (reg_addr)
                KWSR_CTRL_ADDR: begin
                    rdata_r <= {7'h00, level_mode_r};
                end
                KWSR_STATUS_ADDR: begin
                    rdata_r <= status_word(key_wake_in, stop_mode);
                end
                default: begin
                    rdata_r <= KWSR_RDATA_RESET;
                end
            endcase
        end else begin
            rdata_r <= KWSR_RDATA_RESET;
        end
    end
    assign reg_rdata = rdata_r;

    // =========================================================
    // Release condition
    // Pure gates so the request exists while the core clock is stopped.
    // A key counts only while its enable bit is set and its pin is low.
    genvar k;
    generate
        for (k = 0; k < KWSR_KEYS; k = k + 1) begin : g_key
            assign key_low[k] = key_en_r[k] & ~key_wake_in[k];
        end
    endgenerate
    assign key_release = |key_low;
    assign release_req = stop_pin | key_release;

    // Edge mode ignores keys for release, though they still refuse stop; the pin edge needs the clock running, so a
    // pulse on the pin shorter than one clock period can be missed.
    always_comb begin
        if (level_mode_r) begin
            wake = release_req;
        end else begin
            wake = stop_pin & ~pin_prev_r;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev_r <= KWSR_PIN_PREV_RESET;
        end else begin
            pin_prev_r <= stop_pin;
        end
    end

    // =========================================================
    // Stop state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            KWSR_RUN: begin
                if (stop_cmd && !release_req) begin
                    state_nxt = KWSR_STOPPED;
                end
            end
            KWSR_STOPPED: begin
                if (wake) begin
                    state_nxt = KWSR_RUN;
                end
            end
            default: state_nxt = KWSR_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= KWSR_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Warm-up starts on a refused stop or on a release from stop.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            warmup_r <= KWSR_WARMUP_RESET;
        end else begin
            warmup_r <= (state_r == KWSR_RUN && stop_cmd && release_req) ||
                (state_r == KWSR_STOPPED && wake);
        end
    end
    assign warmup_start = warmup_r;
    assign stop_mode = (state_r == KWSR_STOPPED);

    // =========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_REFUSE: assert property (state_r == KWSR_RUN && stop_cmd &&
        release_req |=> warmup_start && !stop_mode)
        else $error("Stop taken despite release condition.");
    AST_ENTER: assert property (state_r == KWSR_RUN && stop_cmd &&
        !release_req |=> stop_mode && !warmup_start)
        else $error("Stop request not taken.");
    AST_KEY_LEVEL: assert property (stop_mode && level_mode_r &&
        key_release |=> !stop_mode && warmup_start)
        else $error("Enabled low key did not release stop.");
    AST_PIN_LEVEL: assert property (stop_mode && level_mode_r &&
        stop_pin |=> !stop_mode && warmup_start)
        else $error("High stop pin did not release stop.");
    AST_PIN_EDGE: assert property (stop_mode && !level_mode_r &&
        $rose(stop_pin) |=> !stop_mode && warmup_start)
        else $error("Rising stop pin did not release in edge mode.");
    AST_EDGE_KEYS: assert property (stop_mode && !level_mode_r &&
        !stop_pin |=> stop_mode)
        else $error("Left stop without a pin edge.");
    AST_DISABLED: assert property (stop_mode && level_mode_r &&
        !stop_pin && !key_release |=> stop_mode)
        else $error("Disabled or high key released stop.");
    AST_EN_WRITE: assert property (reg_wr &&
        reg_addr == KWSR_ENABLE_ADDR |=> key_en_r == $past(reg_wdata[7:4]))
        else $error("Enable bits not stored from bits 7 to 4.");
    AST_EN_READ: assert property (reg_rd &&
        reg_addr == KWSR_ENABLE_ADDR |=> reg_rdata == 8'h00)
        else $error("Write-only enable register read non-zero.");
    AST_PULSE: assert property (warmup_start && !stop_cmd |=>
        !warmup_start)
        else $error("Warm-up pulse longer than one cycle.");
    AST_STOP_AGAIN: assert property (stop_mode && stop_cmd &&
        !wake |=> stop_mode && !warmup_start)
        else $error("Stop request while stopped was not ignored.");
    AST_NO_WARMUP: assert property (!stop_mode && !stop_cmd |=>
        !warmup_start)
        else $error("Warm-up started without a stop request.");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data stood outside the read cycle.");
    AST_MODE_READ: assert property (reg_rd &&
        reg_addr == KWSR_CTRL_ADDR |=>
        reg_rdata == {7'h00, $past(level_mode_r)})
        else $error("Release mode read back wrong.");

    COV_REFUSE: cover property (stop_cmd && release_req && !stop_mode);
    COV_KEY_WAKE: cover property (stop_mode && level_mode_r &&
        key_release ##1 warmup_start);
    COV_PIN_WAKE: cover property (stop_mode && level_mode_r &&
        stop_pin ##1 warmup_start);
    COV_EDGE_WAKE: cover property (stop_mode && !level_mode_r &&
        $rose(stop_pin));

endmodule // kwsr_key_wakeup_unit

`default_nettype wire

// File: core/kwu_pkg.sv
// Constants and types for the key-on wakeup stop-release unit.
package kwsr_pkg;
    // =========================================================
    // Register map
    localparam logic [11:0] KWSR_ENABLE_ADDR = 12'hf9f;
    localparam logic [11:0] KWSR_CTRL_ADDR = 12'hfa0;
    localparam logic [11:0] KWSR_STATUS_ADDR = 12'hfa1;
    // =========================================================
    // Field positions and reset values
    localparam int KWSR_EN_LSB = 4;
    localparam int KWSR_EN_MSB = 7;
    localparam int KWSR_KEYS = 4;
    localparam int KWSR_REL_MODE_BIT = 0;
    localparam int KWSR_STAT_STOP_BIT = 0;
    localparam int KWSR_STAT_KEY_LSB = 4;
    localparam logic [3:0] KWSR_EN_RESET = 4'h0;
    localparam logic KWSR_REL_MODE_RESET = 1'h1;
    localparam logic [7:0] KWSR_RDATA_RESET = 8'h00;
    localparam logic KWSR_PIN_PREV_RESET = 1'h0;
    localparam logic KWSR_WARMUP_RESET = 1'h0;
    // =========================================================
    // Stop-state machine
    typedef enum logic [1:0] {
        KWSR_RUN = 2'h1,
        KWSR_STOPPED = 2'h2
    } kwsr_state_t;
endpackage

// File: sim/kwu_key_model.sv
// Model of the key switches and stop-release pin wiring.
`timescale 1ns/1ps
`default_nettype none
module kwsr_key_model (
    input wire logic [3:0] press,
    input wire logic pin_hi,
    output logic [3:0] key_wake_in,
    output logic stop_pin
);
    // Pull-ups keep keys high unless pressed.
    assign key_wake_in = ~press;
    // Keys are plain logic levels; none is also an analog input.
    // The pin rests low while keys do the waking.
    assign stop_pin = pin_hi;
endmodule // kwsr_key_model
`default_nettype wire

// File: sim/kwu_tb_top.sv
// Self-checking bench for the key-on wakeup unit.
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_stop_release_tb_top;
    import kwsr_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic stop_cmd = 1'b0, pin_hi = 1'b0, stop_pin, release_req;
    logic stop_mode, warmup_start;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
    logic [3:0] press = 4'h0, key_wake_in;
    int n_fail = 0, total_checks = 0, cycles = 0;
    kwsr_key_wakeup_unit DUT (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_wake_in(key_wake_in),
        .stop_pin(stop_pin), .stop_cmd(stop_cmd), .release_req(release_req),
        .stop_mode(stop_mode), .warmup_start(warmup_start));
    kwsr_key_model keys (.press(press), .pin_hi(pin_hi),
        .key_wake_in(key_wake_in), .stop_pin(stop_pin));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // Outputs are judged 1 ns after the edge that samples the change.
    task automatic act(input logic [3:0] p, input logic h);
        @(posedge clock);
        press <= p;
        pin_hi <= h;
        @(posedge clock);
        #1;
    endtask
    task automatic go();
        @(posedge clock);
        stop_cmd <= 1'b1;
        @(posedge clock);
        stop_cmd <= 1'b0;
        #1;
    endtask
    task automatic s_regs();
        rd(KWSR_ENABLE_ADDR);
        chk("enable read", rd_val, 8'h00);
        rd(KWSR_CTRL_ADDR);
        chk("mode reset", rd_val, 8'h01);
        rd(12'h000);
        chk("unmapped", rd_val, 8'h00);
    endtask
    task automatic s_keys();
        for (int i = 0; i < KWSR_KEYS; i++) begin
            wr(KWSR_ENABLE_ADDR, 8'h10 << i);
            go();
            chk("stop entry", {7'h00, stop_mode}, 8'h01);
            act(4'h1 << ((i + 1) % 4), 1'b0);
            chk("other key", {7'h00, stop_mode}, 8'h01);
            chk("other req", {7'h00, release_req}, 8'h00);
            act(4'h1 << i, 1'b0);
            chk("wake", {stop_mode, warmup_start}, 8'h01);
            act(4'h0, 1'b0);
        end
    endtask
    task automatic s_refuse();
        wr(KWSR_ENABLE_ADDR, 8'h20);
        act(4'h2, 1'b0);
        chk("key req", {7'h00, release_req}, 8'h01);
        go();
        chk("key refusal", {stop_mode, warmup_start}, 8'h01);
        act(4'h0, 1'b1);
        chk("pin req", {7'h00, release_req}, 8'h01);
        go();
        chk("pin refusal", {stop_mode, warmup_start}, 8'h01);
        act(4'h0, 1'b0);
    endtask
    task automatic s_pin();
        wr(KWSR_ENABLE_ADDR, 8'h00);
        go();
        rd(KWSR_STATUS_ADDR);
        chk("status", rd_val, 8'hf1);
        go();
        chk("stop again", {stop_mode, warmup_start}, 8'h02);
        act(4'h0, 1'b1);
        chk("pin wake", {stop_mode, warmup_start}, 8'h01);
        act(4'h0, 1'b0);
        chk("pulse end", {stop_mode, warmup_start}, 8'h00);
    endtask
    task automatic s_edge();
        wr(KWSR_CTRL_ADDR, 8'h00);
        wr(KWSR_ENABLE_ADDR, 8'hf0);
        go();
        act(4'h8, 1'b0);
        chk("edge key", {7'h00, stop_mode}, 8'h01);
        act(4'h0, 1'b0);
        act(4'h0, 1'b1);
        chk("edge wake", {stop_mode, warmup_start}, 8'h01);
        act(4'h0, 1'b0);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // A hang is cut short well beyond the under one hundred cycles needed.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        s_regs();
        s_keys();
        s_refuse();
        s_pin();
        s_edge();
        summarize();
    end
endmodule // key_wakeup_stop_release_tb_top
`default_nettype wire
